// File: logic/rps_consts.svh
// Timing counts, reset values and field constants for the receiver reset and power sequencer.
`ifndef RPS_CONSTS_SVH
`define RPS_CONSTS_SVH
`define RPS_CLK_MHZ          100
`define RPS_RESET_HOLD_US    1000
`define RPS_OSC_SETTLE_US    500
`define RPS_RX_STARTUP_US    1000
`define RPS_PULSE_NS         100
`define RPS_CLK_PERIOD_NS    10
`define RPS_STATUS_RESET     8'hFF
`define RPS_STATUS_CLEAR     8'h00
`endif

// File: logic/rps_pkg.sv
// Types shared by the receiver reset and power sequencer.
package rps_pkg;
    typedef enum logic [3:0] {
        RPS_POWER_DOWN,
        RPS_BROWN_OUT,
        RPS_RECOVER_PULSE,
        RPS_RESET_HOLD,
        RPS_SLEEP,
        RPS_OSC_SETTLE,
        RPS_RF_START,
        RPS_RUN
    } rps_state_type;
endpackage

// File: logic/rps_sequencer.sv
// Power-down, power-on reset, brown-out reset and sleep-to-run sequencer.
//
// Functional notes
// RULE1: Power-on input low holds power-down with every regulator off.
// RULE2: Power-on rising edge enables digital regulators and starts a power-on reset.
// RULE3: Analog regulator is on only while the receiver-active output is high.
// RULE4: Brown-out report forces reset and discards stored configuration.
// RULE5: Between brown-out and functional threshold the interrupt strobe is driven low.
// RULE6: On supply recovery pulse the strobe high, then hold reset for hold time.
// RULE7: Leaving reset loads status register with all ones and drives strobe low.
// RULE8: After reset the controller starts in sleep and accepts commands.
// RULE9: First status read after reset releases the strobe high.
// RULE10: Entering sleep puts oscillator in low power with load capacitors off.
// RULE11: Leaving sleep: precise oscillator, settle, then RF path and PLL, then ready.
// RULE12: Hold, settle and startup delays are parameterised clock counters.
`timescale 1ns/1ps
`include "rps_consts.svh"
module rps_sequencer #(
    parameter int RESET_HOLD_US = `RPS_RESET_HOLD_US,
    parameter int OSC_SETTLE_US = `RPS_OSC_SETTLE_US,
    parameter int RX_STARTUP_US = `RPS_RX_STARTUP_US,
    parameter int CNT_W         = 20
) (
    input  wire logic        clk_i,
    input  wire logic        reset_n_i,
    input  wire logic        power_on_i,
    input  wire logic        brown_out_i,
    input  wire logic        status_read_i,
    input  wire logic        run_request_i,
    input  wire logic        sleep_request_i,
    input  wire logic [7:0]  status_event_i,
    output logic             digital_reg_en_o,
    output logic             analog_reg_en_o,
    output logic             logic_reset_n_o,
    output logic             config_clear_o,
    output logic             interrupt_strobe_output_o,
    output logic [7:0]       interrupt_status_register_o,
    output logic             cmd_ready_o,
    output logic             osc_high_precision_o,
    output logic             load_caps_en_o,
    output logic             rf_path_en_o,
    output logic             pll_en_o,
    output logic             rx_active_o,
    output logic             rx_ready_o
);
    import rps_pkg::*;

    // Sequence overview. The power-on pin and the brown-out report are filtered first, so
    // every reaction to either lags its pin by four to five clocks.
    // Power-on low wins over everything and parks the block in power-down, regulators off.
    // A filtered power-on rise starts the reset hold. A brown-out report in any powered
    // state parks the block in the brown-out state until the report clears; a high strobe
    // pulse then follows, and after it the same reset hold as for power-on.
    // Leaving the hold lands in sleep with the status register full of ones and the strobe
    // low, and the strobe stays low until the host's first status read.
    // From sleep, a run request switches the oscillator to high precision, waits for it to
    // settle, starts the RF path and PLL, and only then raises the ready flag.
    // A sleep request in any of those steps drops all of them within one clock, trading a
    // cleaner abort for having to pay the full settle time again on the next run request.

    // Delay counts derived from the clock rate; all run on the single system clock.
    localparam int HOLD_CYC   = RESET_HOLD_US * `RPS_CLK_MHZ;
    localparam int SETTLE_CYC = OSC_SETTLE_US * `RPS_CLK_MHZ;
    localparam int START_CYC  = RX_STARTUP_US * `RPS_CLK_MHZ;
    localparam int PULSE_CYC  = (`RPS_PULSE_NS + `RPS_CLK_PERIOD_NS - 1) / `RPS_CLK_PERIOD_NS;
    localparam int RF_CYC     = (START_CYC > SETTLE_CYC) ? START_CYC - SETTLE_CYC : 1;

    // Converts a cycle count to the load value of a down counter that counts to zero.
    function automatic logic [CNT_W-1:0] load_of(input int cycles);
        load_of = (cycles > 1) ? CNT_W'(cycles - 1) : '0;
    endfunction

    // True for every state in which the digital logic is held in reset. The same decode
    // refuses host reads and drives the reset output, so the two can never disagree about
    // the clock in which reset ends.
    function automatic logic held_in_reset(input rps_state_type st);
        case (st)
            RPS_POWER_DOWN,
            RPS_BROWN_OUT,
            RPS_RECOVER_PULSE,
            RPS_RESET_HOLD: held_in_reset = 1'b1;
            default:        held_in_reset = 1'b0;
        endcase
    endfunction

    // Three-stage synchronisers; a change counts once stages two and three agree.
    logic [2:0] pon_sync_ff;
    logic [2:0] bod_sync_ff;
    logic       pon_ff;
    logic       bod_ff;
    logic       pon_prev_ff;

    // Stage one may go metastable, so only the shift into stage two reads it; the filter
    // below looks at stages two and three alone.
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pon_sync_ff <= 3'h0;
            bod_sync_ff <= 3'h0;
        end else begin
            pon_sync_ff <= {pon_sync_ff[1:0], power_on_i};
            bod_sync_ff <= {bod_sync_ff[1:0], brown_out_i};
        end
    end

    // A pin change is believed only once two stages agree; a one-clock glitch on the pin
    // therefore never reaches the sequencer.
    wire pon_agree = pon_sync_ff[1] == pon_sync_ff[2];
    wire bod_agree = bod_sync_ff[1] == bod_sync_ff[2];
    wire nxt_pon   = pon_agree ? pon_sync_ff[2] : pon_ff;
    wire nxt_bod   = bod_agree ? bod_sync_ff[2] : bod_ff;

    // Filtered levels plus previous power-on level for edge detection.
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pon_ff      <= 1'b0;
            bod_ff      <= 1'b0;
            pon_prev_ff <= 1'b0;
        end else begin
            pon_ff      <= nxt_pon;
            bod_ff      <= nxt_bod;
            pon_prev_ff <= pon_ff;
        end
    end

    // Rising edge of the filtered power-on level. Both registers reset low, matching the
    // idle level of the pin, so no false edge follows a chip reset with the pin low.
    wire pon_rise = pon_ff && !pon_prev_ff;

    rps_state_type   state_ff;
    rps_state_type   nxt_state;
    logic [CNT_W-1:0] cnt_ff;
    logic [CNT_W-1:0] nxt_cnt;
    logic [7:0]      status_ff;
    logic [7:0]      nxt_status;
    logic            strobe_ff;
    logic            nxt_strobe;
    logic            first_read_pending_ff;
    logic            nxt_first_read_pending;

    // The down counter is shared by every timed state; each state loads it on entry, so no
    // state inherits a count left behind by another.
    wire cnt_done = cnt_ff == '0;
    wire entering_sleep = (nxt_state == RPS_SLEEP) && (state_ff != RPS_SLEEP);

    // Sequencing. Power-off takes priority over everything; brown-out over everything in any state but power-down.
    always_comb begin
        nxt_state = state_ff;
        nxt_cnt   = cnt_done ? cnt_ff : cnt_ff - 1'b1;
        if (!pon_ff) begin
            nxt_state = RPS_POWER_DOWN; // RULE1
        end else if (bod_ff && state_ff != RPS_POWER_DOWN) begin
            nxt_state = RPS_BROWN_OUT; // RULE4
        end else begin
            case (state_ff)
                RPS_POWER_DOWN: begin
                    if (pon_rise) begin
                        nxt_state = RPS_RESET_HOLD; // RULE2
                        nxt_cnt   = load_of(HOLD_CYC); // RULE12
                    end
                end
                RPS_BROWN_OUT: begin
                    nxt_state = RPS_RECOVER_PULSE; // RULE6
                    nxt_cnt   = load_of(PULSE_CYC);
                end
                RPS_RECOVER_PULSE: begin
                    if (cnt_done) begin
                        nxt_state = RPS_RESET_HOLD; // RULE6
                        nxt_cnt   = load_of(HOLD_CYC); // RULE12
                    end
                end
                RPS_RESET_HOLD: begin
                    if (cnt_done) begin
                        nxt_state = RPS_SLEEP; // RULE8
                    end
                end
                RPS_SLEEP: begin
                    if (run_request_i) begin
                        nxt_state = RPS_OSC_SETTLE; // RULE11
                        nxt_cnt   = load_of(SETTLE_CYC); // RULE12
                    end
                end
                RPS_OSC_SETTLE: begin
                    if (sleep_request_i) begin
                        nxt_state = RPS_SLEEP;
                    end else if (cnt_done) begin
                        nxt_state = RPS_RF_START; // RULE11
                        nxt_cnt   = load_of(RF_CYC); // RULE12
                    end
                end
                RPS_RF_START: begin
                    if (sleep_request_i) begin
                        nxt_state = RPS_SLEEP;
                    end else if (cnt_done) begin
                        nxt_state = RPS_RUN; // RULE11
                    end
                end
                RPS_RUN: begin
                    if (sleep_request_i) begin
                        nxt_state = RPS_SLEEP;
                    end
                end
                default: begin
                    // An illegal state code falls back to power-down, the safest restart.
                    nxt_state = RPS_POWER_DOWN;
                end
            endcase
        end
    end

    // Status register and strobe. A hardware event set beats the read clear in the same cycle.
    wire leaving_reset = (state_ff == RPS_RESET_HOLD) && (nxt_state == RPS_SLEEP);
    wire in_reset      = held_in_reset(state_ff);
    wire read_ok       = status_read_i && !in_reset;

    always_comb begin
        nxt_status             = status_ff;
        nxt_strobe             = strobe_ff;
        nxt_first_read_pending = first_read_pending_ff;
        if (nxt_state == RPS_BROWN_OUT || nxt_state == RPS_POWER_DOWN) begin
            nxt_status = `RPS_STATUS_CLEAR; // RULE4
            nxt_strobe = 1'b0; // RULE5
        end else if (nxt_state == RPS_RECOVER_PULSE) begin
            nxt_strobe = 1'b1; // RULE6
        end else if (nxt_state == RPS_RESET_HOLD) begin
            nxt_strobe = 1'b0;
        end else if (leaving_reset) begin
            nxt_status             = `RPS_STATUS_RESET; // RULE7
            nxt_strobe             = 1'b0; // RULE7
            nxt_first_read_pending = 1'b1;
        end else begin
            if (read_ok) begin
                nxt_status = `RPS_STATUS_CLEAR;
                if (first_read_pending_ff) begin
                    nxt_strobe             = 1'b1; // RULE9
                    nxt_first_read_pending = 1'b0;
                end
            end
            // Events are ORed in after the read clear, so an event in the read cycle is kept.
            nxt_status = nxt_status | status_event_i;
        end
    end

    // Registered state, counter and status.
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_ff              <= RPS_POWER_DOWN;
            cnt_ff                <= '0;
            status_ff             <= `RPS_STATUS_CLEAR;
            strobe_ff             <= 1'b0;
            first_read_pending_ff <= 1'b0;
        end else begin
            state_ff              <= nxt_state;
            cnt_ff                <= nxt_cnt;
            status_ff             <= nxt_status;
            strobe_ff             <= nxt_strobe;
            first_read_pending_ff <= nxt_first_read_pending;
        end
    end

    // Output decode from the next state so every output is a flip-flop aligned with state_ff.
    wire nxt_digital_en = nxt_state != RPS_POWER_DOWN; // RULE2
    wire nxt_rst_n      = !held_in_reset(nxt_state);
    wire nxt_precise    = (nxt_state == RPS_OSC_SETTLE) || (nxt_state == RPS_RF_START) ||
                          (nxt_state == RPS_RUN); // RULE10
    wire nxt_rf         = (nxt_state == RPS_RF_START) || (nxt_state == RPS_RUN); // RULE11
    wire nxt_ready      = nxt_state == RPS_RUN; // RULE11
    wire nxt_clear      = (nxt_state == RPS_BROWN_OUT) || (nxt_state == RPS_POWER_DOWN);

    // The analog regulator follows the receiver-active flag exactly; they share one source.
    // Reset values match power-down, so the pins are safe before the first clock edge.
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            digital_reg_en_o     <= 1'b0;
            analog_reg_en_o      <= 1'b0;
            logic_reset_n_o      <= 1'b0;
            config_clear_o       <= 1'b1;
            osc_high_precision_o <= 1'b0;
            load_caps_en_o       <= 1'b0;
            rf_path_en_o         <= 1'b0;
            pll_en_o             <= 1'b0;
            rx_active_o          <= 1'b0;
            rx_ready_o           <= 1'b0;
            cmd_ready_o          <= 1'b0;
        end else begin
            digital_reg_en_o     <= nxt_digital_en; // RULE1
            analog_reg_en_o      <= nxt_rf; // RULE3
            logic_reset_n_o      <= nxt_rst_n; // RULE4
            config_clear_o       <= nxt_clear; // RULE4
            osc_high_precision_o <= nxt_precise; // RULE11
            load_caps_en_o       <= nxt_precise && !entering_sleep; // RULE10
            rf_path_en_o         <= nxt_rf;
            pll_en_o             <= nxt_rf;
            rx_active_o          <= nxt_rf; // RULE3
            rx_ready_o           <= nxt_ready;
            cmd_ready_o          <= nxt_rst_n; // RULE8
        end
    end

    // Strobe and status come straight from their registers, so the host never sees a
    // combinational glitch on them.
    assign interrupt_strobe_output_o   = strobe_ff;
    assign interrupt_status_register_o = status_ff;
endmodule

// File: sim/rps_sequencer_properties.sv
// Concurrent checks on the ports of the reset and power sequencer.
`timescale 1ns/1ps
module rps_sequencer_properties (
    input wire logic       clk_i,
    input wire logic       reset_n_i,
    input wire logic       power_on_i,
    input wire logic       brown_out_i,
    input wire logic       status_read_i,
    input wire logic       digital_reg_en_o,
    input wire logic       analog_reg_en_o,
    input wire logic       logic_reset_n_o,
    input wire logic       config_clear_o,
    input wire logic       interrupt_strobe_output_o,
    input wire logic       cmd_ready_o,
    input wire logic       osc_high_precision_o,
    input wire logic       load_caps_en_o,
    input wire logic       rf_path_en_o,
    input wire logic       pll_en_o,
    input wire logic       rx_active_o,
    input wire logic       rx_ready_o,
    input wire logic [7:0] interrupt_status_register_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    // Eight quiet cycles cover the input synchronisers before power-down must show.
    property p_pdown; (!power_on_i)[*8] |-> !digital_reg_en_o && !analog_reg_en_o; endproperty
    a_pdown: assert property (p_pdown) else $error("regulators on in power-down");
    property p_pon; $rose(power_on_i) && !brown_out_i |-> ##[1:10] digital_reg_en_o; endproperty
    a_pon: assert property (p_pon) else $error("digital regulators not enabled");
    property p_analog; analog_reg_en_o == rx_active_o; endproperty
    a_analog: assert property (p_analog) else $error("analog regulator mismatch");
    property p_bo; brown_out_i[*8] |-> !logic_reset_n_o && config_clear_o; endproperty
    a_bo: assert property (p_bo) else $error("no reset during brown-out");
    property p_bo_low; brown_out_i[*8] |-> !interrupt_strobe_output_o; endproperty
    a_bo_low: assert property (p_bo_low) else $error("strobe high in brown-out");
    property p_pulse;
        brown_out_i[*8] ##1 (!brown_out_i && power_on_i) |-> ##[0:8] interrupt_strobe_output_o;
    endproperty
    a_pulse: assert property (p_pulse) else $error("no recovery pulse");
    property p_leave;
        $rose(logic_reset_n_o)
            |-> interrupt_status_register_o == 8'hFF && !interrupt_strobe_output_o;
    endproperty
    a_leave: assert property (p_leave) else $error("bad state on leaving reset");
    property p_cmd; $rose(logic_reset_n_o) |-> !rx_active_o ##[0:2] cmd_ready_o; endproperty
    a_cmd: assert property (p_cmd) else $error("not in sleep after reset");
    property p_read;
        !interrupt_strobe_output_o && status_read_i && logic_reset_n_o && cmd_ready_o
            |=> interrupt_strobe_output_o;
    endproperty
    a_read: assert property (p_read) else $error("strobe not released by read");
    property p_sleep; $fell(osc_high_precision_o) |-> !load_caps_en_o && !rf_path_en_o; endproperty
    a_sleep: assert property (p_sleep) else $error("caps left on in sleep");
    property p_settle;
        $rose(rf_path_en_o) |-> pll_en_o && $past(osc_high_precision_o, 8) && !rx_ready_o;
    endproperty
    a_settle: assert property (p_settle) else $error("rf path before settle");
    property p_ready; $rose(rx_ready_o) |-> rf_path_en_o && pll_en_o && osc_high_precision_o;
    endproperty
    a_ready: assert property (p_ready) else $error("ready before rf path");
endmodule
bind rps_sequencer rps_sequencer_properties rps_sequencer_properties_i (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .power_on_i(power_on_i), .brown_out_i(brown_out_i),
    .status_read_i(status_read_i), .digital_reg_en_o(digital_reg_en_o),
    .analog_reg_en_o(analog_reg_en_o), .logic_reset_n_o(logic_reset_n_o),
    .config_clear_o(config_clear_o), .interrupt_strobe_output_o(interrupt_strobe_output_o),
    .cmd_ready_o(cmd_ready_o), .osc_high_precision_o(osc_high_precision_o),
    .load_caps_en_o(load_caps_en_o), .rf_path_en_o(rf_path_en_o), .pll_en_o(pll_en_o),
    .rx_active_o(rx_active_o), .rx_ready_o(rx_ready_o),
    .interrupt_status_register_o(interrupt_status_register_o));

// File: sim/rps_host_model.sv
// Host model that reads the status register once after each reset release.
`timescale 1ns/1ps
module rps_host_model #(
    parameter int DELAY = 4
) (
    input  wire logic clk_i,
    input  wire logic reset_n_i,
    input  wire logic enable_i,
    input  wire logic strobe_i,
    input  wire logic logic_reset_n_i,
    output logic      status_read_o
);
    int   wait_ff;
    logic done_ff;
    // Only the first read matters, so one pulse is issued per reset release. The device's
    // own reset clears the model synchronously, like a host restarting on that event.
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            wait_ff       <= 0;
            done_ff       <= 1'b0;
            status_read_o <= 1'b0;
        end else if (!logic_reset_n_i) begin
            wait_ff       <= 0;
            done_ff       <= 1'b0;
            status_read_o <= 1'b0;
        end else if (enable_i && !done_ff && !strobe_i) begin
            wait_ff       <= wait_ff + 1;
            status_read_o <= (wait_ff == DELAY);
            done_ff       <= (wait_ff == DELAY);
        end else begin
            status_read_o <= 1'b0;
        end
    end
endmodule

// File: sim/testbench.sv
// Scenario testbench for the receiver reset and power sequencer.
`timescale 1ns/1ps
`include "rps_consts.svh"
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin errors++; \
    $display("ERROR t=%0t got %h exp %h", $time, a, b); end end
module testbench;
    localparam int CYC = `RPS_CLK_MHZ;
    localparam int PULSE = `RPS_PULSE_NS / `RPS_CLK_PERIOD_NS;
    logic       clk_i = 0, reset_n_i = 0, power_on_i = 0, brown_out_i = 0, host_en = 0;
    logic       run_request_i = 0, sleep_request_i = 0, status_read_i;
    logic [7:0] status_event_i = 8'h00;
    logic       digital_reg_en_o, analog_reg_en_o, logic_reset_n_o, config_clear_o, strobe;
    logic       cmd_ready_o, osc_high_precision_o, load_caps_en_o, rf_path_en_o, pll_en_o;
    logic       rx_active_o, rx_ready_o;
    logic [7:0] status;
    int         errors = 0, num_checks = 0, n;
    rps_sequencer #(.RESET_HOLD_US(1), .OSC_SETTLE_US(1), .RX_STARTUP_US(2)) rps_sequencer_i (
        .clk_i(clk_i), .reset_n_i(reset_n_i), .power_on_i(power_on_i), .brown_out_i(brown_out_i),
        .status_read_i(status_read_i), .run_request_i(run_request_i),
        .sleep_request_i(sleep_request_i), .status_event_i(status_event_i),
        .digital_reg_en_o(digital_reg_en_o), .analog_reg_en_o(analog_reg_en_o),
        .logic_reset_n_o(logic_reset_n_o), .config_clear_o(config_clear_o),
        .interrupt_strobe_output_o(strobe), .interrupt_status_register_o(status),
        .cmd_ready_o(cmd_ready_o), .osc_high_precision_o(osc_high_precision_o),
        .load_caps_en_o(load_caps_en_o), .rf_path_en_o(rf_path_en_o), .pll_en_o(pll_en_o),
        .rx_active_o(rx_active_o), .rx_ready_o(rx_ready_o));
    rps_host_model #(.DELAY(4)) rps_host_model_i (.clk_i(clk_i), .reset_n_i(reset_n_i),
        .enable_i(host_en), .strobe_i(strobe), .logic_reset_n_i(logic_reset_n_o),
        .status_read_o(status_read_i));
    // Free-running system clock.
    initial begin
        forever #5 clk_i = ~clk_i;
    end
    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    function automatic logic sig(input int sel);
        case (sel)
            0: return digital_reg_en_o;
            1: return logic_reset_n_o;
            2: return osc_high_precision_o;
            3: return rf_path_en_o;
            4: return rx_ready_o;
            default: return strobe;
        endcase
    endfunction
    // Bounded wait, so a stuck sequencer ends the run instead of hanging it.
    task automatic wait_sig(input int sel, input logic lvl, output int cnt);
        cnt = 0;
        while (sig(sel) !== lvl && cnt < 2000) begin
            @(negedge clk_i);
            cnt++;
        end
        if (cnt >= 2000) begin
            errors++;
            $display("ERROR t=%0t got %h exp %h", $time, sig(sel), lvl);
            final_report();
        end
    endtask
    // Power-up from power-down, hold time, then the first host read.
    task automatic t_power_up();
        repeat (10) @(negedge clk_i);
        `CHK({digital_reg_en_o, analog_reg_en_o, config_clear_o}, 3'b001)
        power_on_i = 1'b1;
        wait_sig(0, 1'b1, n);
        `CHK(n <= 10, 1'b1)
        wait_sig(1, 1'b1, n);
        `CHK(n >= CYC - 5 && n <= CYC + 5, 1'b1)
        `CHK({status, strobe, cmd_ready_o, rx_active_o}, 11'h7FA)
        repeat (20) @(negedge clk_i);
        `CHK(strobe, 1'b0)
        host_en = 1'b1;
        wait_sig(5, 1'b1, n);
        `CHK(n <= 8, 1'b1)
        `CHK(status, 8'h00)
        $display("power-up done");
    endtask
    // Event bits gather into the status register.
    task automatic t_events();
        status_event_i = 8'h05;
        @(negedge clk_i);
        status_event_i = 8'h80;
        @(negedge clk_i);
        status_event_i = 8'h00;
        @(negedge clk_i);
        `CHK(status, 8'h85)
        $display("events done");
    endtask
    // Sleep to run ordering and the return to sleep.
    task automatic t_run();
        run_request_i = 1'b1;
        @(negedge clk_i);
        run_request_i = 1'b0;
        wait_sig(2, 1'b1, n);
        `CHK({n <= 1, load_caps_en_o, rf_path_en_o}, 3'b110)
        wait_sig(3, 1'b1, n);
        `CHK(n >= CYC - 4 && n <= CYC + 4, 1'b1)
        `CHK({pll_en_o, rx_active_o, analog_reg_en_o, rx_ready_o}, 4'hE)
        wait_sig(4, 1'b1, n);
        `CHK(n >= CYC - 4 && n <= CYC + 4, 1'b1)
        sleep_request_i = 1'b1;
        @(negedge clk_i);
        sleep_request_i = 1'b0;
        @(negedge clk_i);
        `CHK({osc_high_precision_o, load_caps_en_o, rx_active_o, analog_reg_en_o}, 4'h0)
        // A sleep request during the settle time aborts the start; the RF path never starts.
        run_request_i = 1'b1;
        @(negedge clk_i);
        run_request_i = 1'b0;
        repeat (10) @(negedge clk_i);
        sleep_request_i = 1'b1;
        @(negedge clk_i);
        sleep_request_i = 1'b0;
        repeat (CYC) @(negedge clk_i);
        `CHK({osc_high_precision_o, load_caps_en_o, rf_path_en_o, rx_ready_o, cmd_ready_o}, 5'h01)
        $display("run done");
    endtask
    // Brown-out during the RF start step, recovery pulse and a fresh reset.
    task automatic t_brown_out();
        run_request_i = 1'b1;
        @(negedge clk_i);
        run_request_i = 1'b0;
        wait_sig(3, 1'b1, n);
        brown_out_i = 1'b1;
        repeat (20) @(negedge clk_i);
        `CHK({strobe, logic_reset_n_o, config_clear_o, rx_active_o}, 4'b0010)
        brown_out_i = 1'b0;
        wait_sig(5, 1'b1, n);
        `CHK(n <= 8, 1'b1)
        wait_sig(5, 1'b0, n);
        `CHK(n, PULSE)
        `CHK(logic_reset_n_o, 1'b0)
        wait_sig(1, 1'b1, n);
        `CHK(n >= CYC - 5 && n <= CYC + 5, 1'b1)
        `CHK({status, strobe, cmd_ready_o}, 10'h3FD)
        wait_sig(5, 1'b1, n);
        `CHK(status, 8'h00)
        $display("brown-out done");
    endtask
    // Power-on dropping during the RF start step wins over everything.
    task automatic t_power_down();
        run_request_i = 1'b1;
        @(negedge clk_i);
        run_request_i = 1'b0;
        wait_sig(3, 1'b1, n);
        power_on_i = 1'b0;
        repeat (10) @(negedge clk_i);
        `CHK({digital_reg_en_o, analog_reg_en_o, rf_path_en_o, config_clear_o}, 4'h1)
        $display("power-down done");
    endtask
    // Main sequence.
    initial begin
        repeat (20) @(negedge clk_i);
        reset_n_i = 1'b1;
        t_power_up();
        t_events();
        t_run();
        t_brown_out();
        t_power_down();
        final_report();
    end
endmodule
